// *** logic/mes_pkg.sv ***
// package of constants and register map for the motor error supervisor
package mes_pkg;
  localparam int CLK_HZ = 25000000;
  localparam int UPTIME_TICK_US = 1000; // up-time counts milliseconds
  localparam int UPTIME_TICK_CYC = (CLK_HZ / 1000000) * UPTIME_TICK_US;
  localparam logic [31:0] UPTIME_WRAP_MS = 32'hFFFFFFFF; // 49.7 days in ms
  localparam logic [7:0] BAUD_SYNC_BYTE = 8'hAA;
  localparam logic signed [15:0] SPEED_FULL = 16'sh0C80; // 3200
  localparam logic [15:0] NEUTRAL_LIMIT = 16'h0100; // 8 % of 3200
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_UPTIME = 8'h08;
  localparam logic [7:0] REG_BAUD = 8'h0C;
  localparam logic [7:0] REG_PERIOD = 8'h10;
  localparam logic [7:0] REG_TEMP_LIMIT = 8'h14;
  localparam logic [7:0] REG_TIMEOUT = 8'h18;
  localparam logic [7:0] REG_CMD = 8'h1C;
  localparam logic [7:0] REG_SPEED = 8'h20;
  localparam logic [7:0] REG_CNT_SAFE = 8'h24;
  localparam logic [7:0] REG_CNT_CHAN = 8'h28;
  localparam logic [7:0] REG_CNT_TMO = 8'h2C;
  localparam logic [7:0] REG_CNT_TEMP = 8'h30;
  // ctrl fields
  localparam int CTRL_SAFE_EN = 0;
  localparam int CTRL_MODE_LO = 1; // two bits: mode
  localparam int CTRL_LIMIT_REQ = 3; // channel one used as limit/kill switch
  localparam logic [31:0] CTRL_RESET = 32'h00000001;
  localparam logic [1:0] MODE_SERIAL = 2'h0;
  localparam logic [1:0] MODE_ANALOG = 2'h1;
  localparam logic [1:0] MODE_PULSE = 2'h2;
  // command bits
  localparam int CMD_RESUME = 0;
  localparam int CMD_CLR_COUNTS = 1;
  localparam logic [11:0] TEMP_LIMIT_RESET = 12'h320;
endpackage : mes_pkg

// *** logic/mes_supervisor.sv ***
// motor error supervisor: error decisions, status readings and apb registers
// Contract
// - up-time counter runs from reset and wraps to zero at 49.7 days
// - after reset baud detection runs; baud reads invalid until locked
// - host sends 0xAA; its bit time locks and reports the baud
// - pulse input one period is measured; invalid channel reports not available
// - temperature above configurable threshold stops the motor
// - manual speed accepted only in serial mode with no stopping error
// - fault output high exactly while any error stops the motor
// - each error has an occurrence counter, clearable on request
// - safe start is enabled after reset, can be disabled
// - serial mode with safe start: other stopping error raises safe-start violation
// - serial mode: violation latched until others gone and resume issued
// - analog/pulse mode: violation when stopped and inputs not neutral
// - analog/pulse mode: violation clears when summed input magnitude below 8 %
// - required channel invalid raises a stopping error
// - channel invalid when disconnected or outside configured range
// - channel required if it sets speed or is a limit/kill switch
// - default configuration leaves no channel required
// - serial mode: timeout error when no valid command for configured period
// - speeds and scaled inputs are signed values from -3200 to 3200
// - valid serial command, usb set-speed or exit safe start clears timeout
// - timeout disabled after reset; active only with non-zero value
`timescale 1ns/1ns
module mes_supervisor #(
  parameter int TICK_CYC = mes_pkg::UPTIME_TICK_CYC // cycles per millisecond
) (
  input wire logic pclk, // 25 MHz clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic rx_pin, // serial receive line
  input wire logic pulse_input_one, // pulse input channel one
  input wire logic valid_cmd, // one-cycle pulse: valid serial/usb command
  input wire logic [15:0] scaled_one, // signed scaled value of channel one
  input wire logic [15:0] scaled_two, // signed scaled value of channel two
  input wire logic [1:0] chan_disc, // channel disconnected flags
  input wire logic [1:0] chan_range_bad, // channel outside error range flags
  input wire logic [11:0] temp_reading, // board temperature reading
  input wire logic [15:0] target_speed, // signed target from input source
  output logic [15:0] applied_speed, // signed applied motor speed
  output logic fault // error stopping the motor, drives red lamp
);
  typedef enum logic [2:0] {
    MES_IDLE = 3'b001,
    MES_START = 3'b010,
    MES_LOCK = 3'b100
  } mes_baud_e;
  typedef struct packed {
    logic rx_s1, rx_s2, rx_prev;
    logic pi_s1, pi_s2, pi_prev;
    mes_baud_e bstate;
    logic [19:0] bcnt;
    logic [19:0] bit_cyc;
    logic baud_ok;
    logic [23:0] pcnt;
    logic [23:0] period;
    logic [15:0] tick;
    logic [31:0] uptime;
    logic [31:0] ctrl;
    logic [11:0] temp_limit;
    logic [31:0] timeout_ms;
    logic [31:0] idle_ms;
    logic tmo_err;
    logic safe_err;
    logic [3:0] err_prev;
    logic [31:0] cnt_safe, cnt_chan, cnt_tmo, cnt_temp;
    logic [15:0] manual_speed;
    logic [15:0] speed_out;
    logic [31:0] rdata;
  } mes_state_s;
  mes_state_s r, n;
  logic [1:0] mode;
  logic serial_mode, chan_req_one, chan_inv_one, chan_inv_two, req_one, req_two;
  logic chan_err, temp_err, others, stop, neutral, wr, rd, mapped, resume, clr_counts;
  logic [15:0] abs_one, abs_two;
  logic [16:0] abs_sum;
  logic [3:0] err_now;
  function automatic logic [15:0] mes_abs(input logic [15:0] v);
    mes_abs = v[15] ? 16'(-v) : v;
  endfunction : mes_abs
  // decode of configuration and error conditions
  always_comb begin
    mode = r.ctrl[mes_pkg::CTRL_MODE_LO +: 2];
    serial_mode = (mode == mes_pkg::MODE_SERIAL);
    chan_inv_one = chan_disc[0] | chan_range_bad[0];
    chan_inv_two = chan_disc[1] | chan_range_bad[1];
    // serial mode sets speed from commands, so default config has nothing required
    req_one = !serial_mode | r.ctrl[mes_pkg::CTRL_LIMIT_REQ];
    req_two = (mode == mes_pkg::MODE_ANALOG);
    chan_req_one = req_one;
    chan_err = (chan_req_one & chan_inv_one) | (req_two & chan_inv_two);
    temp_err = temp_reading > r.temp_limit;
    others = chan_err | temp_err | r.tmo_err;
    // neutral test sums magnitudes; channel two only counts where it sets speed
    abs_one = mes_abs(scaled_one);
    abs_two = req_two ? mes_abs(scaled_two) : 16'h0000;
    abs_sum = {1'b0, abs_one} + {1'b0, abs_two};
    neutral = abs_sum < {1'b0, mes_pkg::NEUTRAL_LIMIT};
    stop = others | r.safe_err;
    // apb strobes; reads decode in setup so the access phase needs no wait state
    wr = psel & penable & pwrite;
    rd = psel & !pwrite;
    mapped = (paddr[1:0] == 2'h0) && (paddr <= mes_pkg::REG_CNT_TEMP);
    resume = wr && paddr == mes_pkg::REG_CMD && pwdata[mes_pkg::CMD_RESUME];
    clr_counts = wr && paddr == mes_pkg::REG_CMD && pwdata[mes_pkg::CMD_CLR_COUNTS];
    err_now = {temp_err, r.tmo_err, chan_err, r.safe_err};
  end
  assign fault = stop;
  assign applied_speed = r.speed_out;
  assign prdata = r.rdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & !mapped;
  // next-state logic for all state
  always_comb begin
    n = r;
    n.rx_s1 = rx_pin;
    n.rx_s2 = r.rx_s1;
    n.rx_prev = r.rx_s2;
    n.pi_s1 = pulse_input_one;
    n.pi_s2 = r.pi_s1;
    n.pi_prev = r.pi_s2;
    // up-time in ms, natural 32-bit wrap is the 49.7 day rollover
    if (r.tick == 16'(TICK_CYC - 1)) begin
      n.tick = 16'h0000;
      n.uptime = r.uptime + 32'h00000001;
    end else begin
      n.tick = r.tick + 16'h0001;
    end
    // baud lock: start bit and bit 0 of 0xAA are both low, so the first low pulse
    // spans two bit times and half of its length is the bit time
    case (r.bstate)
      MES_IDLE: begin
        if (r.rx_prev && !r.rx_s2) begin
          n.bstate = MES_START;
          n.bcnt = 20'h00001;
        end
      end
      MES_START: begin
        if (r.rx_s2) begin
          n.bit_cyc = {1'b0, r.bcnt[19:1]};
          n.baud_ok = 1'b1;
          n.bstate = MES_LOCK;
        end else begin
          n.bcnt = r.bcnt + 20'h00001;
        end
      end
      MES_LOCK: n.bstate = MES_LOCK;
      default: n.bstate = MES_IDLE;
    endcase
    // period between rising edges of pulse input one
    n.pcnt = (r.pcnt == 24'hFFFFFF) ? r.pcnt : r.pcnt + 24'h000001;
    if (r.pi_s2 && !r.pi_prev) begin
      n.period = r.pcnt;
      n.pcnt = 24'h000001;
    end
    // command timeout, counted in ms ticks
    if (valid_cmd || resume) begin
      n.idle_ms = 32'h00000000;
      n.tmo_err = 1'b0;
    end else if (r.tick == 16'(TICK_CYC - 1) && r.idle_ms != 32'hFFFFFFFF) begin
      n.idle_ms = r.idle_ms + 32'h00000001;
    end
    if (serial_mode && r.timeout_ms != 32'h00000000 && r.idle_ms >= r.timeout_ms &&
        !valid_cmd && !resume) begin
      n.tmo_err = 1'b1;
    end
    // other modes take speed from live inputs, so a host silence means nothing there
    if (!serial_mode) begin
      n.tmo_err = 1'b0;
    end
    // safe start violation
    if (!r.ctrl[mes_pkg::CTRL_SAFE_EN]) begin
      n.safe_err = 1'b0;
    end else if (serial_mode) begin
      if (others) begin
        n.safe_err = 1'b1;
      end else if (resume) begin
        n.safe_err = 1'b0;
      end
    end else begin
      if (others && !neutral) begin
        n.safe_err = 1'b1;
      end else if (neutral) begin
        n.safe_err = 1'b0;
      end
    end
    // occurrence counters count rising edges; a new event beats a clear
    n.err_prev = err_now;
    if (clr_counts) begin
      n.cnt_safe = 32'h00000000;
      n.cnt_chan = 32'h00000000;
      n.cnt_tmo = 32'h00000000;
      n.cnt_temp = 32'h00000000;
    end
    if (err_now[0] && !r.err_prev[0]) n.cnt_safe = (clr_counts ? 32'h0 : r.cnt_safe) + 32'h1;
    if (err_now[1] && !r.err_prev[1]) n.cnt_chan = (clr_counts ? 32'h0 : r.cnt_chan) + 32'h1;
    if (err_now[2] && !r.err_prev[2]) n.cnt_tmo = (clr_counts ? 32'h0 : r.cnt_tmo) + 32'h1;
    if (err_now[3] && !r.err_prev[3]) n.cnt_temp = (clr_counts ? 32'h0 : r.cnt_temp) + 32'h1;
    // register writes
    if (wr) begin
      case (paddr)
        mes_pkg::REG_CTRL: n.ctrl = {28'h0, pwdata[3:0]};
        mes_pkg::REG_TEMP_LIMIT: n.temp_limit = pwdata[11:0];
        mes_pkg::REG_TIMEOUT: n.timeout_ms = pwdata;
        mes_pkg::REG_SPEED: begin
          if (serial_mode && !stop) begin
            n.manual_speed = pwdata[15:0];
          end
        end
        default: n.ctrl = n.ctrl;
      endcase
    end
    // a stopping error also drops any stored manual speed so no restart surprise
    if (stop) begin
      n.manual_speed = 16'h0000;
    end
    // applied speed
    if (stop) begin
      n.speed_out = 16'h0000;
    end else begin
      n.speed_out = serial_mode ? r.manual_speed : target_speed;
    end
    // read data captured in setup phase, stable through the access phase
    // zero wait states: the word is in place one cycle before the master takes it
    if (rd && !penable) begin
      case (paddr)
        mes_pkg::REG_CTRL: n.rdata = r.ctrl;
        mes_pkg::REG_STATUS: n.rdata = {24'h0, r.baud_ok, chan_err, temp_err,
                                        r.tmo_err, r.safe_err, stop, 2'h0};
        mes_pkg::REG_UPTIME: n.rdata = r.uptime;
        mes_pkg::REG_BAUD: n.rdata = r.baud_ok ? {12'h0, r.bit_cyc} : 32'h0;
        mes_pkg::REG_PERIOD: n.rdata = chan_inv_one ? 32'h0 : {8'h0, r.period};
        mes_pkg::REG_TEMP_LIMIT: n.rdata = {20'h0, r.temp_limit};
        mes_pkg::REG_TIMEOUT: n.rdata = r.timeout_ms;
        mes_pkg::REG_SPEED: n.rdata = {16'h0, r.speed_out};
        mes_pkg::REG_CNT_SAFE: n.rdata = r.cnt_safe;
        mes_pkg::REG_CNT_CHAN: n.rdata = r.cnt_chan;
        mes_pkg::REG_CNT_TMO: n.rdata = r.cnt_tmo;
        mes_pkg::REG_CNT_TEMP: n.rdata = r.cnt_temp;
        default: n.rdata = 32'h0;
      endcase
    end
  end
  // state register
  // rx sync flops reset high like the idle line, so no false start edge follows reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.rx_s1 <= 1'b1;
      r.rx_s2 <= 1'b1;
      r.rx_prev <= 1'b1;
      r.bstate <= MES_IDLE;
      r.ctrl <= mes_pkg::CTRL_RESET;
      r.temp_limit <= mes_pkg::TEMP_LIMIT_RESET;
    end else begin
      r <= n;
    end
  end
  // checks
  property p_fault_temp;
    @(posedge pclk) disable iff (!presetn) temp_reading > r.temp_limit |-> fault;
  endproperty
  a_fault_temp: assert property (p_fault_temp) else $error("over-temp without fault");
  property p_stop_zero;
    @(posedge pclk) disable iff (!presetn) fault |=> (applied_speed == 16'h0000) || !$past(fault);
  endproperty
  a_stop_zero: assert property (p_stop_zero) else $error("speed not zero in fault");
  property p_baud_na;
    @(posedge pclk) disable iff (!presetn) !r.baud_ok |-> r.bstate != MES_LOCK;
  endproperty
  a_baud_na: assert property (p_baud_na) else $error("baud locked flag mismatch");
  property p_chan_err;
    @(posedge pclk) disable iff (!presetn) (req_one && chan_inv_one) |-> fault;
  endproperty
  a_chan_err: assert property (p_chan_err) else $error("required channel invalid missed");
  property p_safe_serial;
    @(posedge pclk) disable iff (!presetn)
      (serial_mode && r.ctrl[0] && others) |=> r.safe_err;
  endproperty
  a_safe_serial: assert property (p_safe_serial) else $error("safe start not raised");
  property p_safe_hold;
    @(posedge pclk) disable iff (!presetn)
      (serial_mode && r.safe_err && !resume && r.ctrl[0] && $stable(r.ctrl)) |=> r.safe_err;
  endproperty
  a_safe_hold: assert property (p_safe_hold) else $error("safe start dropped early");
  property p_tmo_off;
    @(posedge pclk) disable iff (!presetn) r.timeout_ms == 32'h0 |=> !$rose(r.tmo_err);
  endproperty
  a_tmo_off: assert property (p_tmo_off) else $error("timeout with zero period");
  property p_tmo_clear;
    @(posedge pclk) disable iff (!presetn) valid_cmd |=> !r.tmo_err;
  endproperty
  a_tmo_clear: assert property (p_tmo_clear) else $error("command did not clear timeout");
  property p_uptime;
    @(posedge pclk) disable iff (!presetn)
      r.tick == 16'(TICK_CYC - 1) |=> r.uptime == $past(r.uptime) + 32'h1;
  endproperty
  a_uptime: assert property (p_uptime) else $error("uptime not advanced");
  // receiver, status readings and manual speed
  property p_lock_set;
    @(posedge pclk) disable iff (!presetn)
      (r.bstate == MES_START && r.rx_s2) |=> r.baud_ok;
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("baud lock not flagged");
  property p_lock_once;
    @(posedge pclk) disable iff (!presetn)
      r.bstate == MES_LOCK |=> $stable(r.bit_cyc) && r.baud_ok;
  endproperty
  a_lock_once: assert property (p_lock_once) else $error("locked bit time moved");
  property p_period_na;
    @(posedge pclk) disable iff (!presetn)
      (rd && !penable && paddr == mes_pkg::REG_PERIOD && chan_inv_one) |=> prdata == 32'h00000000;
  endproperty
  a_period_na: assert property (p_period_na) else $error("period shown for invalid input");
  property p_speed_stop;
    @(posedge pclk) disable iff (!presetn)
      (wr && paddr == mes_pkg::REG_SPEED && stop) |=> r.manual_speed == 16'h0000;
  endproperty
  a_speed_stop: assert property (p_speed_stop) else $error("manual speed taken in fault");
  // error counters and safe start
  property p_cnt_temp;
    @(posedge pclk) disable iff (!presetn)
      (temp_err && !r.err_prev[3]) |=>
      r.cnt_temp == ($past(clr_counts) ? 32'h00000001 : $past(r.cnt_temp) + 32'h00000001);
  endproperty
  a_cnt_temp: assert property (p_cnt_temp) else $error("over-temp not counted");
  property p_cnt_clear;
    @(posedge pclk) disable iff (!presetn)
      (clr_counts && err_now == 4'h0) |=> (r.cnt_safe | r.cnt_chan | r.cnt_tmo | r.cnt_temp) == 32'h0;
  endproperty
  a_cnt_clear: assert property (p_cnt_clear) else $error("counters not cleared");
  property p_safe_off;
    @(posedge pclk) disable iff (!presetn)
      !r.ctrl[mes_pkg::CTRL_SAFE_EN] |=> !r.safe_err;
  endproperty
  a_safe_off: assert property (p_safe_off) else $error("safe start while disabled");
  property p_resume_clr;
    @(posedge pclk) disable iff (!presetn)
      (serial_mode && resume && !others) |=> !r.safe_err;
  endproperty
  a_resume_clr: assert property (p_resume_clr) else $error("resume did not clear");
  property p_safe_analog;
    @(posedge pclk) disable iff (!presetn)
      (!serial_mode && r.ctrl[mes_pkg::CTRL_SAFE_EN] && others && !neutral) |=> r.safe_err;
  endproperty
  a_safe_analog: assert property (p_safe_analog) else $error("input safe start missed");
  property p_neutral_clr;
    @(posedge pclk) disable iff (!presetn)
      (!serial_mode && neutral) |=> !r.safe_err;
  endproperty
  a_neutral_clr: assert property (p_neutral_clr) else $error("neutral did not clear");
  // channel and timeout errors
  property p_chan_two;
    @(posedge pclk) disable iff (!presetn)
      (mode == mes_pkg::MODE_ANALOG && chan_inv_two) |-> fault;
  endproperty
  a_chan_two: assert property (p_chan_two) else $error("channel two not required");
  property p_default_free;
    @(posedge pclk) disable iff (!presetn)
      (serial_mode && !r.ctrl[mes_pkg::CTRL_LIMIT_REQ]) |-> !chan_err;
  endproperty
  a_default_free: assert property (p_default_free) else $error("channel required in serial");
  property p_tmo_set;
    @(posedge pclk) disable iff (!presetn)
      (serial_mode && r.timeout_ms != 32'h00000000 && r.idle_ms >= r.timeout_ms &&
       !valid_cmd && !resume) |=> r.tmo_err;
  endproperty
  a_tmo_set: assert property (p_tmo_set) else $error("timeout not raised");
  c_lock: cover property (@(posedge pclk) disable iff (!presetn) $rose(r.baud_ok));
  c_tmo: cover property (@(posedge pclk) disable iff (!presetn) $rose(r.tmo_err));
  c_resume: cover property (@(posedge pclk) disable iff (!presetn) $fell(r.safe_err));
  c_neutral: cover property (@(posedge pclk) disable iff (!presetn)
    !serial_mode && $fell(r.safe_err));
  c_period: cover property (@(posedge pclk) disable iff (!presetn) r.pi_s2 && !r.pi_prev);
endmodule : mes_supervisor

// *** bench/mes_host_model.sv ***
// host model: serial sync byte and valid command pulses
`timescale 1ns/1ns
module mes_host_model #(
  parameter int BIT_CYC = 8 // cycles per serial bit
) (
  input wire logic pclk, // system clock
  output logic rx_pin, // serial line, idle high
  output logic valid_cmd // one-cycle valid command pulse
);
  // line idles high so no false start bit is seen
  initial begin
    rx_pin = 1'b1;
    valid_cmd = 1'b0;
  end
  // start bit, eight bits lsb first, stop bit
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge pclk);
      rx_pin <= fr[i];
      repeat (BIT_CYC - 1) @(posedge pclk);
    end
  endtask : send_byte
  // one cycle only, a longer pulse could be taken as two commands
  task automatic command();
    @(posedge pclk);
    valid_cmd <= 1'b1;
    @(posedge pclk);
    valid_cmd <= 1'b0;
  endtask : command
endmodule : mes_host_model

// *** bench/motor_error_supervisor_tb.sv ***
// self-checking bench for the motor error supervisor
`timescale 1ns/1ns
module motor_error_supervisor_tb;
  localparam int TICK = 10;
  localparam int PER = 40;
  localparam int BIT = 8;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, fault, rx_pin, valid_cmd;
  logic pulse_input_one, pulse_on;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] scaled_one, scaled_two, target_speed, applied_speed, spd;
  logic [1:0] chan_disc, chan_range_bad;
  logic [11:0] temp_reading, lim;
  logic [32:0] rq[$];
  int err_count = 0;
  int compares = 0;
  integer seed = 32'hfa9e33c3;
  // 25 MHz clock
  always #20 pclk = ~pclk;
  mes_supervisor #(.TICK_CYC(TICK)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin), .pulse_input_one(pulse_input_one),
    .valid_cmd(valid_cmd), .scaled_one(scaled_one), .scaled_two(scaled_two),
    .chan_disc(chan_disc), .chan_range_bad(chan_range_bad), .temp_reading(temp_reading),
    .target_speed(target_speed), .applied_speed(applied_speed), .fault(fault));
  mes_host_model #(.BIT_CYC(BIT)) host (.pclk(pclk), .rx_pin(rx_pin), .valid_cmd(valid_cmd));
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wrap_up();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up
  // setup then access, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [32:0] exp);
    rq.push_back(exp);
    apb(1'b0, a, 32'h00000000);
  endtask : rd
  // read data and error flag are taken at the completing edge only
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (rq.size() == 0) begin
        err_count++;
        $display("Error at %0t: read data %h arrived with none expected", $time, prdata);
      end else begin
        check({pslverr, prdata}, rq.pop_front());
      end
    end
  end
  // pulse input with a fixed period once enabled
  always begin
    @(posedge pclk);
    if (pulse_on) begin
      pulse_input_one <= 1'b1;
      repeat (PER / 2) @(posedge pclk);
      pulse_input_one <= 1'b0;
      repeat (PER / 2 - 1) @(posedge pclk);
    end
  end
  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    pulse_input_one = 1'b0;
    pulse_on = 1'b0;
    scaled_one = 16'h0000;
    scaled_two = 16'h0000;
    target_speed = 16'h0000;
    chan_disc = 2'b11;
    chan_range_bad = 2'b00;
    temp_reading = 12'h000;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(mes_pkg::REG_CTRL, {1'b0, mes_pkg::CTRL_RESET});
    rd(mes_pkg::REG_STATUS, 33'h000000000);
    check({32'h00000000, fault}, 33'h000000000);
    rd(mes_pkg::REG_BAUD, 33'h000000000);
    rd(mes_pkg::REG_TIMEOUT, 33'h000000000);
    rd(mes_pkg::REG_TEMP_LIMIT, {21'h000000, mes_pkg::TEMP_LIMIT_RESET});
    rd(8'h34, 33'h100000000);
    host.send_byte(mes_pkg::BAUD_SYNC_BYTE);
    repeat (4) @(posedge pclk);
    rd(mes_pkg::REG_STATUS, 33'h000000080);
    rd(mes_pkg::REG_BAUD, {1'b0, 32'(BIT)});
    // over-temperature with safe start latching behind it
    lim = 12'($random(seed));
    lim[11] = 1'b0;
    apb(1'b1, mes_pkg::REG_TEMP_LIMIT, {20'h00000, lim});
    temp_reading <= lim;
    repeat (3) @(posedge pclk);
    check({32'h00000000, fault}, 33'h000000000);
    temp_reading <= lim + 12'h001;
    repeat (3) @(posedge pclk);
    rd(mes_pkg::REG_STATUS, 33'h0000000AC);
    temp_reading <= lim;
    apb(1'b1, mes_pkg::REG_SPEED, 32'h00000400);
    repeat (3) @(posedge pclk);
    check({17'h00000, applied_speed}, 33'h000000000);
    rd(mes_pkg::REG_STATUS, 33'h00000008C);
    apb(1'b1, mes_pkg::REG_CMD, 32'h00000001);
    repeat (2) @(posedge pclk);
    rd(mes_pkg::REG_STATUS, 33'h000000080);
    rd(mes_pkg::REG_CNT_TEMP, 33'h000000001);
    rd(mes_pkg::REG_CNT_SAFE, 33'h000000001);
    spd = 16'($random(seed) % 3201);
    apb(1'b1, mes_pkg::REG_SPEED, {{16{spd[15]}}, spd});
    repeat (2) @(posedge pclk);
    check({17'h00000, applied_speed}, {17'h00000, spd});
    apb(1'b1, mes_pkg::REG_CMD, 32'h00000002);
    rd(mes_pkg::REG_CNT_TEMP, 33'h000000000);
    // command timeout with safe start off
    apb(1'b1, mes_pkg::REG_CTRL, 32'h00000000);
    apb(1'b1, mes_pkg::REG_TIMEOUT, 32'h00000002);
    repeat (4 * TICK) @(posedge pclk);
    rd(mes_pkg::REG_STATUS, 33'h000000094);
    check({17'h00000, applied_speed}, 33'h000000000);
    host.command();
    repeat (2) @(posedge pclk);
    check({32'h00000000, fault}, 33'h000000000);
    apb(1'b1, mes_pkg::REG_TIMEOUT, 32'h00000000);
    repeat (4 * TICK) @(posedge pclk);
    check({32'h00000000, fault}, 33'h000000000);
    rd(mes_pkg::REG_CNT_TMO, 33'h000000001);
    // analog mode: both channels required, neutral boundary at 256
    chan_disc <= 2'b00;
    target_speed <= 16'h0500;
    apb(1'b1, mes_pkg::REG_CTRL, 32'h00000003);
    scaled_one <= 16'h009C;
    scaled_two <= 16'hFF9C;
    chan_range_bad <= 2'b10;
    repeat (3) @(posedge pclk);
    check({17'h00000, applied_speed}, 33'h000000000);
    rd(mes_pkg::REG_STATUS, 33'h0000000CC);
    chan_range_bad <= 2'b00;
    repeat (3) @(posedge pclk);
    rd(mes_pkg::REG_STATUS, 33'h00000008C);
    scaled_one <= 16'h009B;
    repeat (3) @(posedge pclk);
    rd(mes_pkg::REG_STATUS, 33'h000000080);
    check({17'h00000, applied_speed}, 33'h000000500);
    // pulse mode period, then channel one disconnected
    apb(1'b1, mes_pkg::REG_CTRL, 32'h00000005);
    pulse_on <= 1'b1;
    repeat (4 * PER) @(posedge pclk);
    rd(mes_pkg::REG_PERIOD, {1'b0, 32'(PER)});
    chan_disc <= 2'b01;
    repeat (3) @(posedge pclk);
    rd(mes_pkg::REG_PERIOD, 33'h000000000);
    // second reset in mid-run brings back the power-up defaults
    presetn <= 1'b0;
    temp_reading <= 12'h000;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(mes_pkg::REG_CTRL, {1'b0, mes_pkg::CTRL_RESET});
    rd(mes_pkg::REG_BAUD, 33'h000000000);
    rd(mes_pkg::REG_STATUS, 33'h000000000);
    rd(mes_pkg::REG_CNT_TMO, 33'h000000000);
    wrap_up();
  end
  // watchdog far beyond the sequence length of about five hundred cycles
  initial begin
    #(40 * 5000);
    err_count++;
    wrap_up();
  end
endmodule : motor_error_supervisor_tb
